// *** core/scs_cfg_mem.sv ***
// configuration byte store in the system clock domain
// assumes: requests arrive as a toggle with fields held stable until answered
`timescale 1ns/1ns
module scs_cfg_mem
  import scs_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      req_tog,
  input  wire logic                      req_we,
  input  wire logic [scs_pkg::CFG_AW-1:0] req_addr,
  input  wire logic [7:0]                req_wdata,
  output logic                           ack_tog,
  output logic      [7:0]                rdata,
  output logic                           cfg_wr_pulse,
  output logic      [scs_pkg::CFG_AW-1:0] cfg_wr_addr,
  output logic      [7:0]                cfg_wr_data
);

  logic [7:0] mem [CFG_DEPTH];
  logic       tog_s;
  logic       tog_q;
  wire        new_req = tog_s ^ tog_q;

  scs_sync #(.W(1)) u_req_sync (
    .clock (clock),
    .d     (req_tog),
    .q     (tog_s)
  );

  // ------------------------------------------------------------
  // request service
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        mem[i] <= CFG_RESET_VALUE;
      end
      tog_q        <= 1'b0;
      ack_tog      <= 1'b0;
      rdata        <= CFG_RESET_VALUE;
      cfg_wr_pulse <= 1'b0;
      cfg_wr_addr  <= '0;
      cfg_wr_data  <= 8'h00;
    end else begin
      tog_q        <= tog_s;
      cfg_wr_pulse <= 1'b0;
      if (new_req) begin
        if (req_we) begin
          mem[req_addr] <= req_wdata; // RULE8
          cfg_wr_pulse  <= 1'b1;
          cfg_wr_addr   <= req_addr;
          cfg_wr_data   <= req_wdata;
        end
        rdata   <= req_we ? req_wdata : mem[req_addr];
        ack_tog <= ~ack_tog;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_write_lands: assert property (new_req && req_we |=> // RULE2
    mem[$past(req_addr)] == $past(req_wdata) && cfg_wr_pulse)
    else $error("written byte not stored");
  a_ack_answers: assert property (new_req |=> ack_tog != $past(ack_tog)) // RULE1
    else $error("request not answered");

endmodule : scs_cfg_mem

// *** core/scs_config_slave.sv ***
// two-wire serial configuration slave, top level
// assumes: link_clock samples the bus well faster than the serial clock;
// the serial clock low time spans at least eight link_clock cycles
//
// How it works
// (RULE1) two-wire port, open-drain data line, clock input, reaches config bytes
// (RULE2) byte, word and block reads and writes are all served
// (RULE3) command bit 7 low means block, high means indexed byte or word
// (RULE4) indexed transfers take the byte offset from command bits 6 to 0
// (RULE5) host sets the offset bits to zero for block transfers
// (RULE6) an all-zero command byte starts a block transfer
// (RULE7) block bytes move in ascending order from byte zero, one per data byte
// (RULE8) a stop after any whole byte keeps bytes already written
// (RULE9) host opens with start, seven-bit address, write bit, command byte
// (RULE10) device acknowledges address, command, count and every written data byte
// (RULE11) block write sends an eight-bit count, then data from byte zero, then stop
// (RULE12) block read: repeated start, read bit, device returns count first
// (RULE13) host acks count and data, not-acks last byte, then stops
// (RULE14) word transfer uses a command with bit 7 set and an offset
// (RULE15) word write sends low then high byte, both acknowledged, then stop
// (RULE16) word read returns low then high byte; host not-acks the high byte
// (RULE17) byte write carries one data byte; byte read returns one byte
// (RULE18) bits move most significant first, bytes from zero upward
// (RULE19) host writes zero into unused configuration bits
// (RULE20) only the fixed slave address is answered; otherwise data stays released
// (RULE21) word low byte at the offset, high byte at the next offset
// (RULE22) data sampled while clock high, driven changes only while clock low
`timescale 1ns/1ns
module scs_config_slave
  import scs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = scs_pkg::SLAVE_ADDR_DEF
) (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      link_clock,
  input  wire logic                      serial_clock_pin,
  input  wire logic                      serial_data_pin_in,
  output logic                           serial_data_pin_out,
  output logic                           serial_data_pin_oe,
  output logic                           cfg_wr_pulse,
  output logic      [scs_pkg::CFG_AW-1:0] cfg_wr_addr,
  output logic      [7:0]                cfg_wr_data
);

  // ------------------------------------------------------------
  // link-side state
  // ------------------------------------------------------------
  scs_state_t          state;
  logic                link_rst;
  logic                scl_s;
  logic                sda_s;
  logic                scl_q;
  logic                sda_q;
  logic [3:0]          bitcnt;
  logic [7:0]          rx;
  logic [7:0]          tx;
  logic                rw;
  logic                is_block;
  logic                need_count;
  logic                host_ack;
  logic [CFG_AW-1:0]   ptr;
  logic                req_tog;
  logic                req_we;
  logic [CFG_AW-1:0]   req_addr;
  logic [7:0]          req_wdata;
  logic                ack_tog;
  logic                ack_s;
  logic                ack_q;
  logic [7:0]          rdata_sys;
  logic [7:0]          rdata_link;

  function automatic logic is_rx(input scs_state_t st);
    return (st == ST_ADDR) || (st == ST_CMD) || (st == ST_WDATA);
  endfunction : is_rx

  function automatic logic is_wack(input scs_state_t st);
    return (st == ST_CMD_ACK) || (st == ST_WDATA_ACK);
  endfunction : is_wack

  // ------------------------------------------------------------
  // pin, reset and acknowledge synchronisers
  // ------------------------------------------------------------
  scs_sync #(.W(2)) u_pin_sync ( // RULE1
    .clock (link_clock),
    .d     ({serial_clock_pin, serial_data_pin_in}),
    .q     ({scl_s, sda_s})
  );

  scs_sync #(.W(1)) u_rst_sync (
    .clock (link_clock),
    .d     (sys_rst),
    .q     (link_rst)
  );

  scs_sync #(.W(1)) u_ack_sync (
    .clock (link_clock),
    .d     (ack_tog),
    .q     (ack_s)
  );

  // ------------------------------------------------------------
  // bus event decode
  // ------------------------------------------------------------
  wire             scl_rise  = scl_s & ~scl_q;
  wire             scl_fall  = ~scl_s & scl_q;
  wire             start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire             stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire             byte_end  = scl_fall & (bitcnt == BITS_PER_BYTE);
  wire [7:0]       next_rx   = {rx[6:0], sda_s};
  wire             addr_hit  = (rx[7:1] == SLAVE_ADDR);
  wire             cmd_index = rx[CMD_TYPE_BIT];
  wire [7:0]       out_byte  = need_count ? BLOCK_COUNT : rdata_link;
  wire [CFG_AW-1:0] ptr_next = ptr + 7'h01;

  // ------------------------------------------------------------
  // read data capture from the system domain, and delayed bus samples
  // ------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      ack_q      <= 1'b0;
      rdata_link <= 8'h00;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      ack_q <= ack_s;
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (ack_s != ack_q) begin
        rdata_link <= rdata_sys;
      end
    end
  end

  // ------------------------------------------------------------
  // protocol engine
  // ------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      state               <= ST_IDLE;
      serial_data_pin_oe  <= 1'b0;
      serial_data_pin_out <= 1'b0;
      bitcnt              <= 4'h0;
      rx                  <= 8'h00;
      tx                  <= 8'h00;
      rw                  <= 1'b0;
      is_block            <= 1'b0;
      need_count          <= 1'b0;
      host_ack            <= 1'b0;
      ptr                 <= '0;
      req_tog             <= 1'b0;
      req_we              <= 1'b0;
      req_addr            <= '0;
      req_wdata           <= 8'h00;
    end else if (stop_det) begin
      state              <= ST_IDLE;
      serial_data_pin_oe <= 1'b0;
    end else if (start_det) begin
      state              <= ST_ADDR; // RULE9
      bitcnt             <= 4'h0;
      serial_data_pin_oe <= 1'b0;
    end else begin
      if (is_rx(state) && scl_rise) begin
        rx     <= next_rx; // RULE18
        bitcnt <= bitcnt + 4'h1;
      end
      case (state)
        ST_ADDR: begin
          if (byte_end && addr_hit) begin
            serial_data_pin_oe <= 1'b1; // RULE10
            rw                 <= rx[0];
            state              <= ST_ADDR_ACK;
            if (rx[0]) begin
              req_we   <= 1'b0;
              req_addr <= ptr;
              req_tog  <= ~req_tog;
            end
          end else if (byte_end) begin
            state <= ST_IDLE; // RULE20
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall && rw) begin
            tx                 <= {out_byte[6:0], 1'b0}; // RULE12
            serial_data_pin_oe <= ~out_byte[7];
            bitcnt             <= 4'h1;
            state              <= ST_RDATA;
          end else if (scl_fall) begin
            serial_data_pin_oe <= 1'b0;
            bitcnt             <= 4'h0;
            state              <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_end) begin
            serial_data_pin_oe <= 1'b1;
            is_block           <= ~cmd_index; // RULE3
            need_count         <= ~cmd_index; // RULE6
            ptr                <= cmd_index ? rx[6:0] : '0; // RULE4 RULE14
            state              <= ST_CMD_ACK;
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            serial_data_pin_oe <= 1'b0; // RULE22
            bitcnt             <= 4'h0;
            state              <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_end) begin
            serial_data_pin_oe <= 1'b1;
            state              <= ST_WDATA_ACK;
            if (need_count) begin
              need_count <= 1'b0; // RULE11
            end else begin
              req_we    <= 1'b1; // RULE8
              req_addr  <= ptr;
              req_wdata <= rx;
              req_tog   <= ~req_tog;
              ptr       <= ptr_next; // RULE7 RULE21
            end
          end
        end
        ST_RDATA: begin
          if (byte_end) begin
            serial_data_pin_oe <= 1'b0;
            state              <= ST_RACK;
            if (need_count) begin
              need_count <= 1'b0;
            end else begin
              ptr      <= ptr_next; // RULE21
              req_we   <= 1'b0;
              req_addr <= ptr_next;
              req_tog  <= ~req_tog;
            end
          end else if (scl_fall) begin
            serial_data_pin_oe <= ~tx[7]; // RULE18
            tx                 <= {tx[6:0], 1'b0};
            bitcnt             <= bitcnt + 4'h1;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            host_ack <= ~sda_s; // RULE22
          end
          if (scl_fall && host_ack) begin
            tx                 <= {out_byte[6:0], 1'b0}; // RULE16
            serial_data_pin_oe <= ~out_byte[7];
            bitcnt             <= 4'h1;
            state              <= ST_RDATA;
          end else if (scl_fall) begin
            state <= ST_IDLE; // RULE17
          end
        end
        default: begin
          serial_data_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // system-domain byte store
  // ------------------------------------------------------------
  scs_cfg_mem u_mem (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .req_tog      (req_tog),
    .req_we       (req_we),
    .req_addr     (req_addr),
    .req_wdata    (req_wdata),
    .ack_tog      (ack_tog),
    .rdata        (rdata_sys),
    .cfg_wr_pulse (cfg_wr_pulse),
    .cfg_wr_addr  (cfg_wr_addr),
    .cfg_wr_data  (cfg_wr_data)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking lcb @(posedge link_clock); endclocking
  default disable iff (link_rst);

  a_addr_mismatch: assert property ( // RULE20
    state == ST_ADDR && byte_end && !addr_hit && !start_det && !stop_det
    |=> state == ST_IDLE && !serial_data_pin_oe)
    else $error("foreign address not ignored");
  a_addr_ack: assert property ( // RULE10
    state == ST_ADDR && byte_end && addr_hit && !start_det && !stop_det
    |=> serial_data_pin_oe && state == ST_ADDR_ACK)
    else $error("own address not acknowledged");
  a_sda_when_low: assert property ( // RULE22
    $changed(serial_data_pin_oe) && !$past(stop_det) && !$past(start_det)
    |-> $past(scl_fall))
    else $error("data line moved outside clock low");
  a_block_select: assert property ( // RULE6
    state == ST_CMD && byte_end && !start_det && !stop_det
    |=> is_block == ($past(rx) == CMD_BLOCK || !$past(rx[7])))
    else $error("command type decoded wrongly");
  a_index_offset: assert property ( // RULE4
    state == ST_CMD && byte_end && rx[7] && !start_det && !stop_det
    |=> ptr == $past(rx[6:0]))
    else $error("index offset not taken");
  a_write_ascend: assert property ( // RULE7
    state == ST_WDATA && byte_end && !need_count && !start_det && !stop_det
    |=> ptr == $past(ptr) + 7'h01 && req_addr == $past(ptr) && req_we)
    else $error("write pointer not ascending");
  a_count_first: assert property ( // RULE12
    state == ST_ADDR_ACK && scl_fall && rw && need_count && !start_det && !stop_det
    |=> serial_data_pin_oe == ~BLOCK_COUNT[7] && state == ST_RDATA)
    else $error("block read did not open with count");
  a_nack_ends: assert property ( // RULE16
    state == ST_RACK && scl_fall && !host_ack && !start_det && !stop_det
    |=> state == ST_IDLE ##1 !serial_data_pin_oe)
    else $error("read not ended by not-acknowledge");
  a_ack_release: assert property ( // RULE10
    is_wack(state) && scl_fall && !start_det && !stop_det
    |=> !serial_data_pin_oe [*2])
    else $error("acknowledge held past its bit");

  c_block_write: cover property (
    state == ST_WDATA_ACK && is_block && req_we && ptr == 7'h02);
  c_block_read: cover property (state == ST_RACK && is_block && host_ack);
  c_word_read: cover property (state == ST_RACK && !is_block && !host_ack);
  c_foreign_addr: cover property (
    state == ST_ADDR && byte_end && !addr_hit);

endmodule : scs_config_slave

// *** core/scs_sync.sv ***
// two flip-flop synchroniser, one lane per bit
// assumes: inputs come from another clock domain or a pin
`timescale 1ns/1ns
module scs_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clock) begin
    meta <= d;
    q    <= meta;
  end

endmodule : scs_sync

// *** pkg/scs_pkg.sv ***
// constants and state type for the two-wire configuration slave
// assumes: one system clock domain and one link sampling clock domain
package scs_pkg;

  localparam int         CFG_AW          = 7;
  localparam int         CFG_DEPTH       = 128;
  // slave address value is arbitrary
  localparam logic [6:0] SLAVE_ADDR_DEF  = 7'h2a;
  localparam logic [7:0] CFG_RESET_VALUE = 8'h00;
  localparam logic [7:0] BLOCK_COUNT     = 8'h80;
  localparam logic [7:0] CMD_BLOCK       = 8'h00;
  localparam int         CMD_TYPE_BIT    = 7;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } scs_state_t;

endpackage : scs_pkg

// *** verification/scs_config_slave_tb.sv ***
// ---------------------------------------------------------------
// self-checking bench for the two-wire configuration slave
// ---------------------------------------------------------------
// assumes: host model drives clock and data; data line has a pull-up
`timescale 1ns/1ns
module scs_config_slave_tb;
  import scs_pkg::*;

  logic        clock;
  logic        sys_rst;
  logic        link_clock;
  logic        scl;
  logic        sda_drv;
  wire logic   sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        cfg_wr_pulse;
  logic [6:0]  cfg_wr_addr;
  logic [7:0]  cfg_wr_data;
  logic [14:0] wr_log[$];
  int          mismatches;
  int          check_count;

  assign sda_line = sda_oe ? sda_out : sda_drv;

  scs_config_slave u_scs_config_slave (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .link_clock          (link_clock),
    .serial_clock_pin    (scl),
    .serial_data_pin_in  (sda_line),
    .serial_data_pin_out (sda_out),
    .serial_data_pin_oe  (sda_oe),
    .cfg_wr_pulse        (cfg_wr_pulse),
    .cfg_wr_addr         (cfg_wr_addr),
    .cfg_wr_data         (cfg_wr_data)
  );

  scs_host_model u_scs_host_model (
    .link_clock (link_clock),
    .sda_line   (sda_line),
    .scl        (scl),
    .sda_drv    (sda_drv)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    link_clock = 1'b0;
    #37;
    forever #80 link_clock = ~link_clock;
  end

  // log of every configuration byte written
  always @(negedge clock) begin
    if (cfg_wr_pulse === 1'b1) begin
      wr_log.push_back({cfg_wr_addr, cfg_wr_data});
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic send(input logic [7:0] b);
    logic ack;
    u_scs_host_model.wr_byte(b, ack);
    check({15'h0, ack}, 16'h1);
  endtask : send

  task automatic open(input logic [7:0] cmd);
    u_scs_host_model.start;
    send({SLAVE_ADDR_DEF, 1'b0});
    send(cmd);
  endtask : open

  task automatic read_phase;
    u_scs_host_model.start;
    send({SLAVE_ADDR_DEF, 1'b1});
  endtask : read_phase

  task automatic read_exp(input logic [7:0] exp, input logic ack);
    logic [7:0] d;
    u_scs_host_model.rd_byte(d, ack);
    check({8'h0, d}, {8'h0, exp});
  endtask : read_exp

  task automatic expect_wr(input logic [6:0] a, input logic [7:0] d);
    logic [14:0] e;
    e = 15'h7fff;
    if (wr_log.size() > 0) e = wr_log.pop_front();
    check({1'b0, e}, {1'b0, a, d});
  endtask : expect_wr

  task automatic no_more_wr;
    check(16'(wr_log.size()), 16'h0);
  endtask : no_more_wr

  task automatic t_byte_write;
    open(8'h85);
    send(8'ha5);
    u_scs_host_model.stop;
    expect_wr(7'h05, 8'ha5);
    no_more_wr;
  endtask : t_byte_write

  task automatic t_word_write;
    open(8'h90);
    send(8'h3c);
    send(8'hc3);
    u_scs_host_model.stop;
    expect_wr(7'h10, 8'h3c);
    expect_wr(7'h11, 8'hc3);
    no_more_wr;
  endtask : t_word_write

  task automatic t_word_read;
    open(8'h90);
    read_phase;
    read_exp(8'h3c, 1'b1);
    read_exp(8'hc3, 1'b0);
    u_scs_host_model.stop;
  endtask : t_word_read

  task automatic t_byte_read;
    open(8'h85);
    read_phase;
    read_exp(8'ha5, 1'b0);
    u_scs_host_model.stop;
  endtask : t_byte_read

  task automatic t_block_write_early_stop;
    open(CMD_BLOCK);
    send(8'h03);
    send(8'h11);
    send(8'h22);
    u_scs_host_model.stop;
    expect_wr(7'h00, 8'h11);
    expect_wr(7'h01, 8'h22);
    no_more_wr;
  endtask : t_block_write_early_stop

  task automatic t_block_read;
    open(CMD_BLOCK);
    read_phase;
    read_exp(BLOCK_COUNT, 1'b1);
    read_exp(8'h11, 1'b1);
    read_exp(8'h22, 1'b1);
    read_exp(8'h00, 1'b0);
    u_scs_host_model.stop;
  endtask : t_block_read

  task automatic t_wrong_addr;
    logic ack;
    u_scs_host_model.start;
    u_scs_host_model.wr_byte({SLAVE_ADDR_DEF ^ 7'h01, 1'b0}, ack);
    check({15'h0, ack}, 16'h0);
    u_scs_host_model.wr_byte(8'h85, ack);
    check({15'h0, ack}, 16'h0);
    u_scs_host_model.stop;
    no_more_wr;
  endtask : t_wrong_addr

  initial begin
    mismatches  = 0;
    check_count = 0;
    sys_rst     = 1'b1;
    repeat (72) @(posedge clock);
    #2 sys_rst = 1'b0;
    repeat (6) @(posedge link_clock);
    t_byte_write;
    t_word_write;
    t_word_read;
    t_byte_read;
    t_wrong_addr;
    t_block_write_early_stop;
    t_block_read;
    summarize;
  end

  initial begin
    #1_000_000;
    mismatches++;
    summarize;
  end

endmodule : scs_config_slave_tb

// *** verification/scs_host_model.sv ***
// ---------------------------------------------------------------
// host controller model for the two-wire configuration port
// ---------------------------------------------------------------
// assumes: line level is resolved by the bench with a pull-up;
// every host change lands 2 ns after a link_clock rising edge
`timescale 1ns/1ns
module scs_host_model (
  input  wire logic link_clock,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  localparam int LOW_CYC  = 10;
  localparam int HIGH_CYC = 5;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_lc(input int n);
    repeat (n) @(posedge link_clock);
    #2;
  endtask : wait_lc

  // start or repeated start: data falls while clock high
  task automatic start;
    sda_drv = 1'b1;
    wait_lc(LOW_CYC);
    scl = 1'b1;
    wait_lc(HIGH_CYC);
    sda_drv = 1'b0;
    wait_lc(HIGH_CYC);
    scl = 1'b0;
  endtask : start

  // one bit: data set while clock low, line sampled at the end of high
  task automatic bit_cycle(input logic b, output logic seen);
    sda_drv = b;
    wait_lc(LOW_CYC);
    scl = 1'b1;
    wait_lc(HIGH_CYC);
    seen = sda_line;
    scl = 1'b0;
  endtask : bit_cycle

  // byte out, most significant bit first, then the acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // byte in, then acknowledge or not-acknowledge
  task automatic rd_byte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(~ack, s);
  endtask : rd_byte

  // stop: data rises while clock high, line left released
  task automatic stop;
    sda_drv = 1'b0;
    wait_lc(LOW_CYC);
    scl = 1'b1;
    wait_lc(HIGH_CYC);
    sda_drv = 1'b1;
    wait_lc(HIGH_CYC);
  endtask : stop

endmodule : scs_host_model
